// File: logic/irq_bank_defines.svh
// register indices, field layouts, reset values and bus codes of the interrupt bank
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_PRI_PORTS_TIMERS    16'hff20
`define IDX_PRI_T8_SER_CLK_LCD  16'hff21
`define IDX_PRI_ADC_TOUCH       16'hff22
`define IDX_EN_INPUT_PORTS      16'hff23
`define IDX_EN_TIMERS_SERIAL    16'hff24
`define IDX_EN_CLOCK_LCD        16'hff25
`define IDX_FLAG_INPUT_PORTS    16'hff27
`define IDX_FLAG_TIMERS_SERIAL  16'hff28
`define IDX_FLAG_CLOCK_LCD      16'hff29

// ----------------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------------
`define MASK_PRI_FULL           8'hff
`define MASK_PRI_ADC_TOUCH      8'hf0
`define MASK_PORT_BYTE          8'hf8
`define MASK_TIMER_BYTE         8'hff
`define MASK_CLOCK_BYTE         8'hfc
`define RESET_BYTE              8'h00

// ----------------------------------------------------------------------------
// priority field positions (low bit of each two-bit level)
// ----------------------------------------------------------------------------
`define POS_UPPER_PORT          6
`define POS_LOWER_PORT          4
`define POS_TIMER_ONE           2
`define POS_TIMER_ZERO          0
`define POS_SHORT_TIMER         6
`define POS_SERIAL              4
`define POS_CLOCK_TIMER         2
`define POS_DISPLAY             0

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// File: logic/irq_bank_pkg.sv
// types shared by the interrupt priority and enable bank
package irq_bank_pkg;

  typedef logic [1:0] level_t;

  typedef struct packed {
    logic [7:0] clockByte;
    logic [7:0] timerByte;
    logic [7:0] portByte;
  } irq_bytes_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_lite_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_lite_rsp_t;

  typedef enum {
    SEL_PRI0, SEL_PRI1, SEL_PRI2, SEL_EN_PORT, SEL_EN_TIMER, SEL_EN_CLOCK,
    SEL_FL_PORT, SEL_FL_TIMER, SEL_FL_CLOCK, SEL_NONE
  } reg_sel_t;

endpackage

// File: logic/irq_level_arbiter.sv
// picks the highest pending level, lowest source index winning a tie
module irq_level_arbiter #(
  parameter int N  = 19,
  parameter int IW = 5
) (
  input  wire logic [N-1:0]   pending,
  input  wire logic [2*N-1:0] levels,
  output logic [1:0]          bestLevel,
  output logic [IW-1:0]       bestIndex
);

  always_comb begin
    bestLevel = 2'h0;
    bestIndex = '0;
    // ascending scan with strict compare keeps the fixed default order
    for (int i = 0; i < N; i++) begin
      if (pending[i] && (levels[2*i +: 2] > bestLevel)) begin
        bestLevel = levels[2*i +: 2];
        bestIndex = IW'(i);
      end
    end
  end

endmodule

// File: logic/irq_priority_enable_bank.sv
// interrupt priority, enable and factor flag registers behind an axi4-lite slave
//
// Functional notes
// RULE1 - each group level is two bits, 11 level 3 down to 00 level 0 which never requests.
// RULE2 - the first priority register holds upper port, lower port, timer one, timer zero levels.
// RULE3 - port enable bits 7 to 4 gate upper pins 3 to 0, bit 3 the shared lower port.
// RULE4 - timer enable bit 7 short timer, bits 6/5 timer one, bits 4/3 timer zero.
// RULE5 - timer enable bits 2, 1, 0 gate serial transmit done, receive done, receive fault.
// RULE6 - clock enable bits 7 to 3 gate minute, 1 hz, 2 hz, 8 hz and 32 hz ticks.
// RULE7 - clock enable bit 2 gates the display transfer, bits 1 and 0 are unused.
// RULE8 - an enable bit at one passes its request, at zero blocks it, and reads back.
// RULE9 - reset clears all levels and enables; unused bits read zero and ignore writes.
// RULE10 - equal levels are settled by a fixed built-in order software cannot change.
// RULE11 - a factor flag sets on its event, reads one, and clears on a written one only.
// RULE12 - the cpu sees the highest level among flagged, enabled, nonzero-level sources.
//
// Chosen here: the AXI4-Lite register port.
`include "irq_bank_defines.svh"

module irq_priority_enable_bank #(
  parameter int NUM_SRC = 19,
  parameter int SRC_IW  = 5
) (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire irq_bank_pkg::axi_lite_req_t axiReq,
  output irq_bank_pkg::axi_lite_rsp_t    axiRsp,
  input  wire irq_bank_pkg::irq_bytes_t  srcEvent,
  output logic                           irqOut_r,
  output logic [1:0]                     irqLevel_r,
  output logic [SRC_IW-1:0]              irqSource_r
);
  import irq_bank_pkg::*;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic              awHeld_r;
  logic [31:0]       awAddr_r;
  logic              wHeld_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic [7:0]        priPort_r;
  logic [7:0]        priMisc_r;
  logic [7:0]        priAdcTouch_r;
  logic [7:0]        enPort_r;
  logic [7:0]        enTimer_r;
  logic [7:0]        enClock_r;
  irq_bytes_t        flag_r;
  irq_bytes_t        flag_nxt;
  irq_bytes_t        flagClear;
  irq_bytes_t        active;
  logic              doWrite;
  logic              byteLane;
  reg_sel_t          wrSel;
  reg_sel_t          rdSel;
  logic [NUM_SRC-1:0]   pending;
  logic [2*NUM_SRC-1:0] srcLevels;
  level_t            upperLvl;
  level_t            lowerLvl;
  level_t            timerOneLvl;
  level_t            timerZeroLvl;
  level_t            shortLvl;
  level_t            serialLvl;
  level_t            clockLvl;
  level_t            displayLvl;
  level_t            bestLevel;
  logic [SRC_IW-1:0] bestIndex;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  function automatic reg_sel_t decodeSel(input logic [31:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if ((addr[31:18] == 14'h0) && (addr[1:0] == 2'h0)) begin
      unique case (addr[17:2])
        `IDX_PRI_PORTS_TIMERS:   sel = SEL_PRI0;
        `IDX_PRI_T8_SER_CLK_LCD: sel = SEL_PRI1;
        `IDX_PRI_ADC_TOUCH:      sel = SEL_PRI2;
        `IDX_EN_INPUT_PORTS:     sel = SEL_EN_PORT;
        `IDX_EN_TIMERS_SERIAL:   sel = SEL_EN_TIMER;
        `IDX_EN_CLOCK_LCD:       sel = SEL_EN_CLOCK;
        `IDX_FLAG_INPUT_PORTS:   sel = SEL_FL_PORT;
        `IDX_FLAG_TIMERS_SERIAL: sel = SEL_FL_TIMER;
        `IDX_FLAG_CLOCK_LCD:     sel = SEL_FL_CLOCK;
        default:                 sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [7:0] readByte(input reg_sel_t sel);
    logic [7:0] val;
    val = 8'h00;
    unique case (sel)
      SEL_PRI0:     val = priPort_r;
      SEL_PRI1:     val = priMisc_r;
      SEL_PRI2:     val = priAdcTouch_r;
      SEL_EN_PORT:  val = enPort_r;
      SEL_EN_TIMER: val = enTimer_r;
      SEL_EN_CLOCK: val = enClock_r;
      SEL_FL_PORT:  val = flag_r.portByte;
      SEL_FL_TIMER: val = flag_r.timerByte;
      SEL_FL_CLOCK: val = flag_r.clockByte;
      SEL_NONE:     val = 8'h00;
    endcase
    return val;
  endfunction

  // --------------------------------------------------------------------------
  // write channel
  // --------------------------------------------------------------------------
  // address and data are taken in either order; the answer waits for both
  assign doWrite  = awHeld_r && wHeld_r && !bvalid_r;
  assign wrSel    = decodeSel(awAddr_r);
  assign byteLane = doWrite && wStrb_r[0];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_r  <= 1'b0;
      awAddr_r  <= 32'h0;
      awready_r <= 1'b1;
    end else if (axiReq.awvalid && awready_r) begin
      awHeld_r  <= 1'b1;
      awAddr_r  <= axiReq.awaddr;
      awready_r <= 1'b0;
    end else if (bvalid_r && axiReq.bready) begin
      awHeld_r  <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      wready_r <= 1'b1;
    end else if (axiReq.wvalid && wready_r) begin
      wHeld_r  <= 1'b1;
      wData_r  <= axiReq.wdata;
      wStrb_r  <= axiReq.wstrb;
      wready_r <= 1'b0;
    end else if (bvalid_r && axiReq.bready) begin
      wHeld_r  <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wrSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (axiReq.bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  assign rdSel = decodeSel(axiReq.araddr);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= `RESP_OKAY;
    end else if (axiReq.arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h0, readByte(rdSel)};
      rresp_r   <= (rdSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_r && axiReq.rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign axiRsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                    bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                    rdata: rdata_r, rresp: rresp_r};

  // --------------------------------------------------------------------------
  // priority and enable registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      priPort_r     <= `RESET_BYTE; // RULE9
      priMisc_r     <= `RESET_BYTE;
      priAdcTouch_r <= `RESET_BYTE;
    end else if (byteLane) begin
      if (wrSel == SEL_PRI0) begin
        priPort_r <= wData_r[7:0] & `MASK_PRI_FULL; // RULE2
      end
      if (wrSel == SEL_PRI1) begin
        priMisc_r <= wData_r[7:0] & `MASK_PRI_FULL;
      end
      if (wrSel == SEL_PRI2) begin
        priAdcTouch_r <= wData_r[7:0] & `MASK_PRI_ADC_TOUCH; // RULE9
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enPort_r  <= `RESET_BYTE; // RULE9
      enTimer_r <= `RESET_BYTE;
      enClock_r <= `RESET_BYTE;
    end else if (byteLane) begin
      if (wrSel == SEL_EN_PORT) begin
        enPort_r <= wData_r[7:0] & `MASK_PORT_BYTE; // RULE3
      end
      if (wrSel == SEL_EN_TIMER) begin
        enTimer_r <= wData_r[7:0] & `MASK_TIMER_BYTE; // RULE4
      end
      if (wrSel == SEL_EN_CLOCK) begin
        enClock_r <= wData_r[7:0] & `MASK_CLOCK_BYTE; // RULE7
      end
    end
  end

  // --------------------------------------------------------------------------
  // factor flags
  // --------------------------------------------------------------------------
  // a fresh event beats a clear landing in the same cycle, so none is lost
  always_comb begin
    flagClear.portByte  = (byteLane && wrSel == SEL_FL_PORT)  ? wData_r[7:0] : 8'h00;
    flagClear.timerByte = (byteLane && wrSel == SEL_FL_TIMER) ? wData_r[7:0] : 8'h00;
    flagClear.clockByte = (byteLane && wrSel == SEL_FL_CLOCK) ? wData_r[7:0] : 8'h00;
    flag_nxt.portByte  = ((flag_r.portByte & ~flagClear.portByte) | srcEvent.portByte)
                         & `MASK_PORT_BYTE; // RULE11
    flag_nxt.timerByte = ((flag_r.timerByte & ~flagClear.timerByte) | srcEvent.timerByte)
                         & `MASK_TIMER_BYTE;
    flag_nxt.clockByte = ((flag_r.clockByte & ~flagClear.clockByte) | srcEvent.clockByte)
                         & `MASK_CLOCK_BYTE;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // request arbitration
  // --------------------------------------------------------------------------
  assign upperLvl     = priPort_r[`POS_UPPER_PORT +: 2]; // RULE2
  assign lowerLvl     = priPort_r[`POS_LOWER_PORT +: 2];
  assign timerOneLvl  = priPort_r[`POS_TIMER_ONE +: 2];
  assign timerZeroLvl = priPort_r[`POS_TIMER_ZERO +: 2];
  assign shortLvl     = priMisc_r[`POS_SHORT_TIMER +: 2];
  assign serialLvl    = priMisc_r[`POS_SERIAL +: 2];
  assign clockLvl     = priMisc_r[`POS_CLOCK_TIMER +: 2];
  assign displayLvl   = priMisc_r[`POS_DISPLAY +: 2];

  // flag and enable share one layout, so gating is a plain and
  assign active.portByte  = flag_r.portByte & enPort_r; // RULE8
  assign active.timerByte = flag_r.timerByte & enTimer_r; // RULE5
  assign active.clockByte = flag_r.clockByte & enClock_r; // RULE6

  // index 0 is the highest default rank: pins, timers, serial, display, clock
  assign pending = {active.clockByte[7:2], active.timerByte[2:0],
                    active.timerByte[7:3], active.portByte[3],
                    active.portByte[7:4]}; // RULE10
  assign srcLevels = {{5{clockLvl}}, displayLvl, {3{serialLvl}}, shortLvl,
                      {2{timerOneLvl}}, {2{timerZeroLvl}}, lowerLvl,
                      {4{upperLvl}}};

  irq_level_arbiter #(
    .N  (NUM_SRC),
    .IW (SRC_IW)
  ) i_irq_level_arbiter (
    .pending   (pending),
    .levels    (srcLevels),
    .bestLevel (bestLevel),
    .bestIndex (bestIndex)
  );

  // level zero never wins the strict compare, so it cannot request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut_r    <= 1'b0;
      irqLevel_r  <= 2'h0;
      irqSource_r <= '0;
    end else begin
      irqOut_r    <= (bestLevel != 2'h0); // RULE1
      irqLevel_r  <= bestLevel; // RULE12
      irqSource_r <= bestIndex;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_LEVEL0_QUIET: assert property ( // RULE1
    (priPort_r == 8'h00 && priMisc_r == 8'h00) [*2] |-> !irqOut_r)
    else $error("request raised with every level at zero");

  AST_UPPER_FIELD: assert property ( // RULE2
    pending[0] && upperLvl == 2'h3 |=> irqLevel_r == 2'h3 && irqSource_r == '0)
    else $error("upper pin request not taken at its field level");

  AST_PORT_UNUSED: assert property (enPort_r[2:0] == 3'h0) // RULE3
    else $error("unused port enable bits not zero");

  AST_CLOCK_UNUSED: assert property (enClock_r[1:0] == 2'h0 && flag_r.clockByte[1:0] == 2'h0) // RULE7
    else $error("unused clock register bits not zero");

  AST_ENABLE_WRITE: assert property ( // RULE8
    byteLane && wrSel == SEL_EN_TIMER |=> enTimer_r == $past(wData_r[7:0]))
    else $error("timer enable write not stored");

  AST_ADC_LOW_ZERO: assert property (priAdcTouch_r[3:0] == 4'h0) // RULE9
    else $error("unused priority bits not zero");

  AST_TIE_ORDER: assert property ( // RULE10
    pending[4] && pending[5] && lowerLvl == timerZeroLvl && lowerLvl != 2'h0
    && pending[3:0] == 4'h0 && bestLevel == lowerLvl |=> irqSource_r == SRC_IW'(4))
    else $error("tie not settled by the fixed order");

  AST_FLAG_SET: assert property ( // RULE11
    srcEvent.timerByte[7] |=> flag_r.timerByte[7])
    else $error("event lost from its factor flag");

  AST_FLAG_HOLD: assert property ( // RULE11
    flag_r.portByte[3] && !flagClear.portByte[3] |=> flag_r.portByte[3])
    else $error("factor flag dropped without a clear");

  AST_LEVEL_CAUSE: assert property ( // RULE12
    irqOut_r |-> $past(bestLevel) == irqLevel_r && $past(|pending))
    else $error("request level without a pending source");

  AST_BRESP_CAUSE: assert property (
    $rose(bvalid_r) |-> $past(awHeld_r && wHeld_r) && !awready_r && !wready_r)
    else $error("write answer without both halves");

endmodule

// File: test/cpu_core_model.sv
// behavioural cpu core that takes leveled interrupt requests
module cpu_core_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       irqOut_r,
  input  wire logic [1:0] irqLevel_r,
  input  wire logic [4:0] irqSource_r,
  input  wire logic [1:0] maskLevel,
  output logic [1:0]      takenLevel,
  output logic [4:0]      takenSource
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // acceptance
  // ----------------------------------------
  // only a level above the core mask is taken, as the core's own flags allow
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      takenLevel  <= 2'h0;
      takenSource <= 5'h00;
    end else if (irqOut_r && irqLevel_r > maskLevel) begin
      takenLevel  <= irqLevel_r;
      takenSource <= irqSource_r;
    end
  end
endmodule

// File: test/irq_priority_enable_bank_test.sv
// self-checking bench for the interrupt priority and enable bank
`include "irq_bank_defines.svh"

`define CHECK(got, want) \
  begin \
    comparisons++; \
    if ((got) !== (want)) begin \
      miscompares++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, want); \
    end \
  end

module irq_priority_enable_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_bank_pkg::*;

  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  wr;
    logic [7:0]  rd;
  } row_t;

  logic          ref_clk;
  logic          arst_n;
  axi_lite_req_t axiReq;
  axi_lite_rsp_t axiRsp;
  irq_bytes_t    srcEvent;
  logic          irqOut_r;
  logic [1:0]    irqLevel_r;
  logic [4:0]    irqSource_r;
  logic [1:0]    maskLevel;
  logic [1:0]    takenLevel;
  logic [4:0]    takenSource;
  logic [7:0]    rdData;
  logic [1:0]    resp;
  int            miscompares;
  int            comparisons;

  // ----------------------------------------
  // tables
  // ----------------------------------------
  row_t rows [9] = '{
    '{`IDX_PRI_PORTS_TIMERS, 8'hff, 8'hff},
    '{`IDX_PRI_PORTS_TIMERS, 8'he7, 8'he7},
    '{`IDX_PRI_T8_SER_CLK_LCD, 8'hff, 8'hff},
    '{`IDX_PRI_T8_SER_CLK_LCD, 8'h6d, 8'h6d},
    '{`IDX_PRI_ADC_TOUCH, 8'hff, 8'hf0},
    '{`IDX_EN_INPUT_PORTS, 8'h00, 8'h00},
    '{`IDX_EN_INPUT_PORTS, 8'hff, 8'hf8},
    '{`IDX_EN_TIMERS_SERIAL, 8'hff, 8'hff},
    '{`IDX_EN_CLOCK_LCD, 8'hff, 8'hfc}
  };
  // event bit of source index i within {clock, timer, port}
  int bitPos [19] = '{4, 5, 6, 7, 3, 11, 12, 13, 14, 15, 8, 9, 10, 18, 19, 20, 21, 22, 23};
  // group level of each source with priorities 8'he7 and 8'h6d
  logic [1:0] lvlOf [19] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1,
                             2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

  irq_priority_enable_bank i_irq_priority_enable_bank (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .axiReq      (axiReq),
    .axiRsp      (axiRsp),
    .srcEvent    (srcEvent),
    .irqOut_r    (irqOut_r),
    .irqLevel_r  (irqLevel_r),
    .irqSource_r (irqSource_r)
  );

  cpu_core_model i_cpu_core_model (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .irqOut_r    (irqOut_r),
    .irqLevel_r  (irqLevel_r),
    .irqSource_r (irqSource_r),
    .maskLevel   (maskLevel),
    .takenLevel  (takenLevel),
    .takenSource (takenSource)
  );

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // ----------------------------------------
  // bus and event tasks
  // ----------------------------------------
  task automatic busWrite(input logic [15:0] idx, input logic [7:0] data, input logic [3:0] strb);
    @(posedge ref_clk);
    axiReq.awaddr  <= {14'h0, idx, 2'h0};
    axiReq.wdata   <= {24'h0, data};
    axiReq.wstrb   <= strb;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    // no wait is bounded here: only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask

  task automatic busRead(input logic [15:0] idx);
    @(posedge ref_clk);
    axiReq.araddr  <= {14'h0, idx, 2'h0};
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    rdData = axiRsp.rdata[7:0];
    resp   = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask

  task automatic expectReg(input logic [15:0] idx, input logic [7:0] want, input logic [1:0] wr);
    busRead(idx);
    `CHECK(rdData, want)
    `CHECK(resp, wr)
  endtask

  // one-cycle event, then the request two edges later
  task automatic fire(input irq_bytes_t ev, input logic on, input logic [1:0] lvl,
                      input logic [4:0] src);
    @(posedge ref_clk);
    srcEvent <= ev;
    @(posedge ref_clk);
    srcEvent <= '0;
    @(posedge ref_clk);
    #1;
    `CHECK(irqOut_r, on)
    `CHECK(irqLevel_r, lvl)
    `CHECK(irqSource_r, src)
  endtask

  task automatic clearAll();
    for (int k = 0; k < 3; k++) busWrite(`IDX_FLAG_INPUT_PORTS + 16'(k), 8'hff, 4'hf);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    axiReq = '0;
    srcEvent = '0;
    maskLevel = 2'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 6; k++) expectReg(`IDX_PRI_PORTS_TIMERS + 16'(k), 8'h00, `RESP_OKAY);
    foreach (rows[k]) begin
      busWrite(rows[k].idx, rows[k].wr, 4'hf);
      expectReg(rows[k].idx, rows[k].rd, `RESP_OKAY);
    end
    for (int i = 0; i < 19; i++) begin
      fire(24'h1 << bitPos[i], 1'b1, lvlOf[i], 5'(i));
      expectReg(`IDX_FLAG_INPUT_PORTS + 16'(bitPos[i] / 8), 8'h1 << (bitPos[i] % 8), `RESP_OKAY);
      `CHECK(takenLevel, lvlOf[i])
      `CHECK(takenSource, 5'(i))
      busWrite(`IDX_FLAG_INPUT_PORTS + 16'(bitPos[i] / 8), 8'hff, 4'hf);
      @(posedge ref_clk);
      #1;
      `CHECK(irqOut_r, 1'b0)
    end
    fire(24'h001800, 1'b1, 2'h3, 5'h05);
    clearAll();
    fire(24'h800010, 1'b1, 2'h3, 5'h00);
    clearAll();
    fire(24'h002100, 1'b1, 2'h2, 5'h0a);
    clearAll();
    // lower port and timer zero on one level: the fixed order picks the port
    busWrite(`IDX_PRI_PORTS_TIMERS, 8'hea, 4'hf);
    fire(24'h000808, 1'b1, 2'h2, 5'h04);
    clearAll();
    busWrite(`IDX_PRI_PORTS_TIMERS, 8'he7, 4'hf);
    // a blocked source still flags and is served once enabled
    busWrite(`IDX_EN_TIMERS_SERIAL, 8'hf7, 4'hf);
    fire(24'h000800, 1'b0, 2'h0, 5'h00);
    busWrite(`IDX_FLAG_TIMERS_SERIAL, 8'h00, 4'hf);
    expectReg(`IDX_FLAG_TIMERS_SERIAL, 8'h08, `RESP_OKAY);
    busWrite(`IDX_EN_TIMERS_SERIAL, 8'hff, 4'hf);
    @(posedge ref_clk);
    #1;
    `CHECK(irqSource_r, 5'h05)
    busWrite(`IDX_PRI_PORTS_TIMERS, 8'he4, 4'hf);
    @(posedge ref_clk);
    #1;
    `CHECK(irqOut_r, 1'b0)
    busWrite(`IDX_PRI_PORTS_TIMERS, 8'h00, 4'h0);
    expectReg(`IDX_PRI_PORTS_TIMERS, 8'he4, `RESP_OKAY);
    busWrite(16'hff26, 8'hff, 4'hf);
    `CHECK(resp, `RESP_SLVERR)
    expectReg(16'hff26, 8'h00, `RESP_SLVERR);
    // reset in mid-run with a request standing
    fire(24'h080000, 1'b1, 2'h3, 5'h0e);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    `CHECK(irqOut_r, 1'b0)
    for (int k = 0; k < 6; k++) expectReg(`IDX_PRI_PORTS_TIMERS + 16'(k), 8'h00, `RESP_OKAY);
    give_verdict();
  end

  // a hang past some ten times the expected run ends it
  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end
endmodule
